// ===== dsc_switch_ctrl.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module dsc_switch_ctrl
    import dsc_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        NRST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Decisions towards filter and extension stages
    output dsc_act_t         ACTIONS,
    output dsc_ext_t         EXT_MODE,
    output logic             SWB_TO_WB,
    output logic             WB_TO_SWB,
    output logic             BUSY
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dsc_state_reg_t r_reg;
    dsc_state_reg_t r_next;

    logic       wr_take;
    logic       narrow;
    logic       widen;
    logic       sr_switch;
    logic       int_switch;
    logic [5:0] w1;
    logic [5:0] s1;
    logic [5:0] w2;
    logic [5:0] s2;
    dsc_ext_t   ext_sel;

    // Mode word packing, used by the mode register read-back only
    function automatic logic [31:0] mode_word(input dsc_frame_t f);
        logic [31:0] v;
        v = '0;
        v[DSC_F_BW_LO +: 2]   = f.bw;
        v[DSC_F_CT_LO +: 3]   = f.coder_type;
        v[DSC_F_CORE_LO +: 2] = f.core;
        v[DSC_F_PPP]          = f.ppp_mode;
        v[DSC_F_LEGACY]       = f.legacy_interop_mode;
        v[DSC_F_IRATE +: 2]   = f.internal_rate;
        v[DSC_F_PF_ON]        = f.pf_on;
        return v;
    endfunction

    // ------------------------------------------------------------
    // Frame decisions
    // ------------------------------------------------------------
    // Ordered code turns narrow/widen into compares
    assign narrow     = r_reg.cur.bw < r_reg.prv.bw;
    assign widen      = r_reg.cur.bw > r_reg.prv.bw;
    assign int_switch = r_reg.cur.internal_rate != r_reg.prv.internal_rate;
    assign sr_switch  = int_switch ||
                        (r_reg.cur.output_sample_rate != r_reg.prv.output_sample_rate);

    // Counter update; second block sees the first block's result
    always_comb begin
        w1 = r_reg.wts_cnt;
        s1 = r_reg.stw_cnt;
        if (r_reg.wts_cnt >= DSC_WTS_LIMIT) begin
            w1 = '0;
        end else if (r_reg.cur.bw == DSC_BW_SWB && r_reg.cur.total_brate > DSC_BR_9K6 &&
                     r_reg.prv.bw == DSC_BW_WB && r_reg.prv.total_brate <= DSC_BR_9K6) begin
            w1 = r_reg.wts_cnt + DSC_CNT_ONE;
        end else if (r_reg.wts_cnt != '0) begin
            if (narrow) begin
                w1 = '0;
                s1 = 6'((DSC_WTS_LIMIT - r_reg.wts_cnt) << 1) - DSC_CNT_ONE;
            end else if (r_reg.cur.bw == DSC_BW_SWB) begin
                w1 = r_reg.wts_cnt + DSC_CNT_ONE;
                s1 = '0;
            end else begin
                w1 = '0;
                s1 = '0;
            end
        end
        w2 = w1;
        s2 = s1;
        if (s1 >= DSC_STW_LIMIT) begin
            s2 = '0;
        end else if (r_reg.cur.total_brate <= DSC_BR_9K6 && r_reg.prv.total_brate > DSC_BR_9K6 &&
                     narrow && r_reg.cur.bw == DSC_BW_WB) begin
            s2 = s1 + DSC_CNT_ONE;
        end else if (s1 != '0) begin
            if (widen) begin
                s2 = '0;
                w2 = (DSC_STW_LIMIT - s1) >> 1;
            end else if (r_reg.cur.bw == DSC_BW_WB) begin
                s2 = s1 + DSC_CNT_ONE;
                w2 = '0;
            end else begin
                s2 = '0;
                w2 = '0;
            end
        end
    end

    // Upper-band regeneration choice, from the fresh counter
    always_comb begin
        ext_sel = DSC_EXT_NONE;
        if (r_reg.cur.core == DSC_CORE_ALGEBRAIC_CELP_CORE) begin
            if (r_reg.cur.output_sample_rate >= DSC_FS_32K && r_reg.cur.bw > DSC_BW_NB &&
                s2 != '0 && !r_reg.cur.ppp_mode) begin
                if (r_reg.cur.coder_type != DSC_CT_AUDIO &&
                    r_reg.cur.coder_type != DSC_CT_INACTIVE &&
                    r_reg.cur.core_brate > DSC_BR_2K4) begin
                    ext_sel = DSC_EXT_TIME;
                end else begin
                    ext_sel = DSC_EXT_FREQ;
                end
            end
        end else if (s2 != '0) begin
            ext_sel = DSC_EXT_PRED;
        end
    end

    assign wr_take = PSEL && PENABLE && r_reg.pready && PWRITE && !r_reg.pslverr;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next         = r_reg;
        r_next.pready  = 1'b0;
        r_next.act     = '0;

        // APB setup cycle: decode, prepare answer for access phase
        if (PSEL && !PENABLE) begin
            r_next.pready  = 1'b1;
            r_next.prdata  = '0;
            r_next.pslverr = 1'b0;
            if (PADDR == DSC_ADDR_CTRL) begin
                r_next.prdata = {31'h0, r_reg.busy};
            end else if (PADDR == DSC_ADDR_TBRATE) begin
                r_next.prdata = r_reg.stage.total_brate;
            end else if (PADDR == DSC_ADDR_CBRATE) begin
                r_next.prdata = r_reg.stage.core_brate;
            end else if (PADDR == DSC_ADDR_ORATE) begin
                r_next.prdata = r_reg.stage.output_sample_rate;
            end else if (PADDR == DSC_ADDR_MODE) begin
                r_next.prdata = mode_word(r_reg.stage);
            end else if (PADDR == DSC_ADDR_STATUS) begin
                r_next.pslverr = PWRITE;     // Read-only word
                r_next.prdata  = {16'h0, r_reg.ext, r_reg.wts_flag, r_reg.stw_flag,
                                  r_reg.wts_cnt, r_reg.stw_cnt};
            end else begin
                r_next.pslverr = 1'b1;
            end
        end

        // Writes land in the staging copy only; frame strobe publishes them
        if (wr_take) begin
            if (PADDR == DSC_ADDR_TBRATE) begin
                r_next.stage.total_brate = PWDATA;
            end else if (PADDR == DSC_ADDR_CBRATE) begin
                r_next.stage.core_brate = PWDATA;
            end else if (PADDR == DSC_ADDR_ORATE) begin
                r_next.stage.output_sample_rate = PWDATA;
            end else if (PADDR == DSC_ADDR_MODE) begin
                r_next.stage.bw                  = dsc_bw_t'(PWDATA[DSC_F_BW_LO +: 2]);
                r_next.stage.coder_type          = dsc_ct_t'(PWDATA[DSC_F_CT_LO +: 3]);
                r_next.stage.core                = dsc_core_t'(PWDATA[DSC_F_CORE_LO +: 2]);
                r_next.stage.ppp_mode            = PWDATA[DSC_F_PPP];
                r_next.stage.legacy_interop_mode = PWDATA[DSC_F_LEGACY];
                r_next.stage.internal_rate       = PWDATA[DSC_F_IRATE +: 2];
                r_next.stage.pf_on               = PWDATA[DSC_F_PF_ON];
            end
        end

        // Frame sequencer; a strobe while busy is dropped
        case (r_reg.fsm)
            DSC_ST_IDLE: begin
                if (wr_take && PADDR == DSC_ADDR_CTRL && PWDATA[0]) begin
                    r_next.prv  = r_reg.cur;
                    r_next.cur  = r_reg.stage;
                    r_next.fsm  = DSC_ST_CFG;
                    r_next.busy = 1'b1;
                end
            end
            DSC_ST_CFG: begin
                // Tools reconfigure before any frame processing
                r_next.act.apply_cfg = r_reg.cur.total_brate != r_reg.prv.total_brate;
                r_next.wts_cnt  = w2;
                r_next.stw_cnt  = s2;
                r_next.stw_flag = s2 != '0;
                r_next.wts_flag = w2 != '0;
                r_next.ext      = ext_sel;
                r_next.fsm      = DSC_ST_SR;
            end
            DSC_ST_SR: begin
                // Rate-dependent memory work, ahead of mode handling
                r_next.act.pf_mem_resample = sr_switch && r_reg.prv.pf_on;
                r_next.act.pf_hold_off     = sr_switch && !r_reg.prv.pf_on;
                r_next.act.pf_smooth_first = r_reg.prv.pf_on && !r_reg.cur.pf_on;
                r_next.act.pf_smooth_resample = r_reg.prv.pf_on && !r_reg.cur.pf_on &&
                                                int_switch;
                r_next.act.bpf_mem_clear = sr_switch &&
                                           (r_reg.cur.total_brate == DSC_BR_9K6 ||
                                            r_reg.cur.total_brate == DSC_BR_16K4 ||
                                            r_reg.cur.total_brate == DSC_BR_24K4);
                r_next.act.fb_resample     = int_switch;
                r_next.act.celp_past_resample = int_switch &&
                                                r_reg.prv.core == DSC_CORE_ALGEBRAIC_CELP_CORE &&
                                                r_reg.cur.core == DSC_CORE_TCX;
                r_next.fsm = DSC_ST_MODE;
            end
            DSC_ST_MODE: begin
                r_next.act.mode_transition = r_reg.cur.core != r_reg.prv.core;
                if (r_reg.cur.legacy_interop_mode && !r_reg.prv.legacy_interop_mode) begin
                    r_next.act.legacy_mem_clear = 1'b1;
                    r_next.act.bass_pf_off      = 1'b1;
                    r_next.act.formant_pf_off   = 1'b1;
                end
                r_next.fsm  = DSC_ST_IDLE;
                r_next.busy = 1'b0;
            end
            default: begin
                r_next.fsm  = DSC_ST_IDLE;
                r_next.busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            r_reg          <= '0;
            r_reg.stage    <= DSC_FRAME_RST;
            r_reg.cur      <= DSC_FRAME_RST;
            r_reg.prv      <= DSC_FRAME_RST;
            r_reg.wts_cnt  <= DSC_WTS_LIMIT;
            r_reg.stw_cnt  <= DSC_STW_LIMIT;
            r_reg.wts_flag <= 1'b1;
            r_reg.stw_flag <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign PRDATA    = r_reg.prdata;
    assign PREADY    = r_reg.pready;
    assign PSLVERR   = r_reg.pslverr;
    assign ACTIONS   = r_reg.act;
    assign EXT_MODE  = r_reg.ext;
    assign SWB_TO_WB = r_reg.stw_flag;
    assign WB_TO_SWB = r_reg.wts_flag;
    assign BUSY      = r_reg.busy;

endmodule

// ===== dsc_pkg.sv
// Contract
// - Reset loads wide-to-superwide counter with 20, superwide-to-wide with 40.
// - Clear first counter at 20; else count up on wide-low to superwide-high rate.
// - Else if first counter nonzero: narrowing reloads other counter; superwide counts.
// - Clear second counter at 40; else count on drop to wide at or below 9600.
// - Else if second counter nonzero: widening reloads first counter; wide keeps counting.
// - Report each transition direction while its counter is nonzero.
// - Time-domain extension needs speech coder, algebraic core, high rates, switching.
// - Otherwise frequency-domain extension for algebraic core, high rate, switching, no pitch mode.
// - Transform core during superwide-to-wide switching predicts upper-band coefficients.
// - Rate switch with post-filter active before resamples post-filter memories.
// - Post-filter off before stays off one frame, memories only filled.
// - Post-filter turning off smooths first subframe only, with resampled memory.
// - At 9.6, 16.4, 24.4 kbps clear bass post-filter memory on rate switch.
// - Internal rate switch resamples both filterbank state sets.
// - Entering legacy mode clears memories and disables both post-filters once.
// - Bitrate change applies new tool configuration first in the frame.
// - Sampling-rate memory updates finish before coding-mode transition handling.
// - CELP to transform switch with rate change resamples past CELP output.
package dsc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  DSC_ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  DSC_ADDR_TBRATE = 8'h04;
    localparam logic [7:0]  DSC_ADDR_CBRATE = 8'h08;
    localparam logic [7:0]  DSC_ADDR_ORATE  = 8'h0c;
    localparam logic [7:0]  DSC_ADDR_MODE   = 8'h10;
    localparam logic [7:0]  DSC_ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // Counter limits and thresholds
    // ------------------------------------------------------------
    localparam logic [5:0]  DSC_WTS_LIMIT   = 6'h14;
    localparam logic [5:0]  DSC_STW_LIMIT   = 6'h28;
    localparam logic [5:0]  DSC_CNT_ONE     = 6'h01;
    localparam logic [31:0] DSC_BR_9K6      = 32'h00002580;
    localparam logic [31:0] DSC_BR_16K4     = 32'h00004010;
    localparam logic [31:0] DSC_BR_24K4     = 32'h00005f50;
    localparam logic [31:0] DSC_BR_2K4      = 32'h00000960;
    localparam logic [31:0] DSC_FS_32K      = 32'h00007d00;
    localparam logic [31:0] DSC_RST_BRATE   = 32'h00002580;
    localparam logic [31:0] DSC_RST_FS      = 32'h00003e80;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DSC_BW_NB  = 2'h0,
        DSC_BW_WB  = 2'h1,
        DSC_BW_SWB = 2'h2,
        DSC_BW_FB  = 2'h3
    } dsc_bw_t;

    typedef enum logic [2:0] {
        DSC_CT_UNVOICED = 3'h0,
        DSC_CT_VOICED   = 3'h1,
        DSC_CT_GENERIC  = 3'h2,
        DSC_CT_TRANS    = 3'h3,
        DSC_CT_AUDIO    = 3'h4,
        DSC_CT_INACTIVE = 3'h5
    } dsc_ct_t;

    typedef enum logic [1:0] {
        DSC_CORE_ALGEBRAIC_CELP_CORE = 2'h0,
        DSC_CORE_TCX   = 2'h1,
        DSC_CORE_MDCT  = 2'h2
    } dsc_core_t;

    typedef enum logic [1:0] {
        DSC_EXT_NONE = 2'h0,
        DSC_EXT_TIME = 2'h1,
        DSC_EXT_FREQ = 2'h2,
        DSC_EXT_PRED = 2'h3
    } dsc_ext_t;

    typedef enum logic [1:0] {
        DSC_ST_IDLE = 2'h0,
        DSC_ST_CFG  = 2'h1,
        DSC_ST_SR   = 2'h2,
        DSC_ST_MODE = 2'h3
    } dsc_state_t;

    // ------------------------------------------------------------
    // Mode register field layout
    // ------------------------------------------------------------
    localparam int DSC_F_BW_LO   = 0;
    localparam int DSC_F_CT_LO   = 2;
    localparam int DSC_F_CORE_LO = 5;
    localparam int DSC_F_PPP     = 7;
    localparam int DSC_F_LEGACY  = 8;
    localparam int DSC_F_IRATE   = 9;
    localparam int DSC_F_PF_ON   = 11;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] total_brate;
        logic [31:0] core_brate;
        logic [31:0] output_sample_rate;
        dsc_bw_t     bw;
        dsc_ct_t     coder_type;
        dsc_core_t   core;
        logic        ppp_mode;
        logic        legacy_interop_mode;
        logic [1:0]  internal_rate;
        logic        pf_on;
    } dsc_frame_t;

    typedef struct packed {
        logic apply_cfg;
        logic pf_mem_resample;
        logic pf_hold_off;
        logic pf_smooth_first;
        logic pf_smooth_resample;
        logic bpf_mem_clear;
        logic fb_resample;
        logic celp_past_resample;
        logic mode_transition;
        logic legacy_mem_clear;
        logic bass_pf_off;
        logic formant_pf_off;
    } dsc_act_t;

    localparam dsc_frame_t DSC_FRAME_RST = '{
        total_brate:         DSC_RST_BRATE,
        core_brate:          DSC_RST_BRATE,
        output_sample_rate:  DSC_RST_FS,
        bw:                  DSC_BW_WB,
        coder_type:          DSC_CT_GENERIC,
        core:                DSC_CORE_ALGEBRAIC_CELP_CORE,
        ppp_mode:            1'b0,
        legacy_interop_mode: 1'b0,
        internal_rate:       2'h0,
        pf_on:               1'b0
    };

    typedef struct packed {
        dsc_state_t fsm;
        logic       busy;
        dsc_frame_t stage;
        dsc_frame_t cur;
        dsc_frame_t prv;
        logic [5:0] wts_cnt;
        logic [5:0] stw_cnt;
        logic       wts_flag;
        logic       stw_flag;
        dsc_ext_t   ext;
        dsc_act_t   act;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
    } dsc_state_reg_t;

endpackage

// ===== dsc_switch_ctrl_sva.sv
`timescale 1ns/100ps
module dsc_switch_ctrl_sva
    import dsc_pkg::*;
(
    // Clock, reset and bus
    input wire logic        CORE_CLK,
    input wire logic        NRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic        PREADY,
    // Decisions
    input wire dsc_act_t    ACTIONS,
    input wire dsc_ext_t    EXT_MODE,
    input wire logic        SWB_TO_WB,
    input wire logic        WB_TO_SWB,
    input wire logic        BUSY
);
    // ----
    // Checks
    // ----
    // One domain, so shared clock and reset
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    ready_wait_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready not one cycle after setup");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held two cycles");
    reset_flags_a: assert property ($rose(NRST) |-> SWB_TO_WB && WB_TO_SWB && !EXT_MODE)
        else $error("flags wrong after reset");
    ext_needs_stw_a: assert property (EXT_MODE != DSC_EXT_NONE |-> SWB_TO_WB)
        else $error("extension chosen without switching");
    flags_in_frame_a: assert property ($changed({SWB_TO_WB, WB_TO_SWB, EXT_MODE}) |-> BUSY)
        else $error("decision changed outside a frame");
    strobe_busy_a: assert property (PSEL && PENABLE && PREADY && PWRITE
        && PADDR == DSC_ADDR_CTRL && PWDATA[0] && !BUSY |=> BUSY)
        else $error("strobe did not start sequencer");
    busy_bound_a: assert property ($rose(BUSY) |-> ##[1:4] !BUSY)
        else $error("sequencer runs too long");
    act_pulse_a: assert property (ACTIONS != 12'h000 |=> (ACTIONS & $past(ACTIONS)) == 12'h000)
        else $error("action held over one cycle");
    cfg_first_a: assert property (ACTIONS.apply_cfg |-> (ACTIONS & 12'h7ff) == 12'h000)
        else $error("configuration not alone first");
    mode_last_a: assert property (ACTIONS.mode_transition |-> !ACTIONS.fb_resample
        && !ACTIONS.celp_past_resample && !ACTIONS.pf_mem_resample)
        else $error("mode handling overlaps rate updates");
    celp_fb_a: assert property (ACTIONS.celp_past_resample |-> ACTIONS.fb_resample)
        else $error("past output resampled without rate change");
    legacy_pf_a: assert property (ACTIONS.legacy_mem_clear |-> ACTIONS.bass_pf_off
        && ACTIONS.formant_pf_off)
        else $error("legacy entry kept a post-filter");
    hold_smooth_a: assert property (ACTIONS.pf_hold_off |-> !ACTIONS.pf_smooth_first
        && !ACTIONS.pf_mem_resample)
        else $error("hold-off mixed with smoothing");
endmodule

bind dsc_switch_ctrl dsc_switch_ctrl_sva chk_u (.CORE_CLK, .NRST, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PREADY, .ACTIONS, .EXT_MODE, .SWB_TO_WB, .WB_TO_SWB, .BUSY);

// ===== dsc_stage_model.sv
`timescale 1ns/100ps
module dsc_stage_model
    import dsc_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     nrst,
    // Decisions from the controller
    input  wire dsc_act_t actions,
    input  wire logic     busy,
    // Pulses gathered over one frame
    output dsc_act_t      seen,
    output logic          done
);
    dsc_act_t acc_reg;
    logic     busy_reg;
    // Gather pulses; a missed one would leave a stage unprepared
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_reg  <= '0;
            busy_reg <= 1'b0;
        end else begin
            acc_reg  <= done ? '0 : seen;
            busy_reg <= busy;
        end
    end
    // Frame ends when the sequencer lets go
    assign seen = acc_reg | actions;
    assign done = busy_reg & ~busy;
endmodule

// ===== decoder_switching_control_tb.sv
`timescale 1ns/100ps
module decoder_switching_control_tb;
    import dsc_pkg::*;
    typedef struct packed {logic err; logic chk; logic [31:0] d;} dsc_note_t;
    typedef struct packed {dsc_act_t a; dsc_ext_t e; logic s; logic w;} dsc_fnote_t;
    logic        CORE_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        SWB_TO_WB, WB_TO_SWB, BUSY, done;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    dsc_act_t    ACTIONS, seen;
    dsc_ext_t    EXT_MODE, mext;
    dsc_frame_t  p, c;
    dsc_note_t   bq[$], bn;
    dsc_fnote_t  fq[$], fm;
    int          fail_count, num_checks, wts, stw, i;
    logic [31:0] brt [4] = '{DSC_BR_9K6, 32'h00003390, DSC_BR_16K4, DSC_BR_24K4};
    logic [31:0] fst [3] = '{DSC_RST_FS, DSC_FS_32K, 32'h0000bb80};

    dsc_switch_ctrl dut_u (.CORE_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .ACTIONS, .EXT_MODE, .SWB_TO_WB, .WB_TO_SWB, .BUSY);
    dsc_stage_model stg_u (.clk(CORE_CLK), .nrst(NRST), .actions(ACTIONS), .busy(BUSY),
        .seen(seen), .done(done));

    // ----
    // Helpers
    // ----
    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input dsc_note_t n);
        bq.push_back(n);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        // Ready looked at mid-cycle, where it has settled
        do @(negedge CORE_CLK); while (PREADY !== 1'b1);
        @(posedge CORE_CLK);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '{1'b0, 1'b0, 32'h0});
    endtask
    function automatic logic [31:0] st();
        return {16'h0, mext, wts != 0, stw != 0, 6'(wts), 6'(stw)};
    endfunction
    // Reference model of one frame, then stimulus
    task automatic frame(input logic dbl);
        int  ow;
        logic ir;
        logic sr;
        ow = wts;
        if (wts >= 20) wts = 0;
        else if (c.bw == DSC_BW_SWB && c.total_brate > DSC_BR_9K6 && p.bw == DSC_BW_WB
                 && p.total_brate <= DSC_BR_9K6) wts++;
        else if (wts > 0) begin
            if (c.bw < p.bw) begin
                wts = 0;
                stw = 2 * (20 - ow) - 1;
            end else begin
                wts = (c.bw == DSC_BW_SWB) ? wts + 1 : 0;
                stw = 0;
            end
        end
        ow = stw;
        if (stw >= 40) stw = 0;
        else if (c.total_brate <= DSC_BR_9K6 && p.total_brate > DSC_BR_9K6 && c.bw < p.bw
                 && c.bw == DSC_BW_WB) stw++;
        else if (stw > 0) begin
            if (c.bw > p.bw) begin
                wts = (40 - ow) / 2;
                stw = 0;
            end else begin
                stw = (c.bw == DSC_BW_WB) ? stw + 1 : 0;
                wts = 0;
            end
        end
        mext = DSC_EXT_NONE;
        if (stw != 0 && c.core != DSC_CORE_ALGEBRAIC_CELP_CORE) mext = DSC_EXT_PRED;
        else if (stw != 0 && c.output_sample_rate >= DSC_FS_32K && c.bw > DSC_BW_NB && !c.ppp_mode)
            mext = (c.coder_type < DSC_CT_AUDIO && c.core_brate > DSC_BR_2K4) ?
                   DSC_EXT_TIME : DSC_EXT_FREQ;
        ir = c.internal_rate != p.internal_rate;
        sr = ir || c.output_sample_rate != p.output_sample_rate;
        fm = '{'0, mext, stw != 0, wts != 0};
        fm.a.apply_cfg = c.total_brate != p.total_brate;
        fm.a.pf_mem_resample = sr && p.pf_on;
        fm.a.bpf_mem_clear = sr && c.total_brate inside {DSC_BR_9K6, DSC_BR_16K4, DSC_BR_24K4};
        fm.a.fb_resample = ir;
        fm.a.celp_past_resample = ir && p.core == DSC_CORE_ALGEBRAIC_CELP_CORE && c.core == DSC_CORE_TCX;
        fm.a.legacy_mem_clear = c.legacy_interop_mode && !p.legacy_interop_mode;
        fm.a.pf_hold_off = sr && !p.pf_on;
        fm.a.pf_smooth_first = p.pf_on && !c.pf_on;
        fm.a.pf_smooth_resample = p.pf_on && !c.pf_on && ir;
        fm.a.mode_transition = c.core != p.core;
        fm.a.bass_pf_off = fm.a.legacy_mem_clear;
        fm.a.formant_pf_off = fm.a.legacy_mem_clear;
        fq.push_back(fm);
        p = c;
        wr(DSC_ADDR_TBRATE, c.total_brate);
        wr(DSC_ADDR_CBRATE, c.core_brate);
        wr(DSC_ADDR_ORATE, c.output_sample_rate);
        wr(DSC_ADDR_MODE, {20'h0, c.pf_on, c.internal_rate, c.legacy_interop_mode,
                           c.ppp_mode, c.core, c.coder_type, c.bw});
        wr(DSC_ADDR_CTRL, 32'h1);
        // A strobe while busy must be dropped
        if (dbl) wr(DSC_ADDR_CTRL, 32'h1);
        do @(negedge CORE_CLK); while (BUSY !== 1'b0);
        apb(1'b0, DSC_ADDR_STATUS, 32'h0, '{1'b0, 1'b1, st()});
    endtask

    // ----
    // Monitors
    // ----
    // Bus answers against the oldest note
    always @(negedge CORE_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1) begin
            bn = bq.pop_front();
            check({31'h0, PSLVERR}, {31'h0, bn.err});
            if (bn.chk) check(PRDATA, bn.d);
        end
    end
    // Frame results when the sequencer finishes
    always @(negedge CORE_CLK) begin
        if (done === 1'b1) begin
            check(fq.size(), 32'h1);
            fm = fq.pop_front();
            check(32'(seen[11:6]), 32'(fm.a[11:6]));
            check(32'(seen[5:0]), 32'(fm.a[5:0]));
            check(32'(EXT_MODE), 32'(fm.e));
            check({30'h0, SWB_TO_WB, WB_TO_SWB}, {30'h0, fm.s, fm.w});
        end
    end
    // Hang guard, well beyond the expected run
    initial begin
        #(50 * 30000);
        fail_count++;
        final_report();
    end

    // ----
    // Main sequence
    // ----
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {fail_count, num_checks, wts, stw} = {32'd0, 32'd0, 32'd20, 32'd40};
        mext = DSC_EXT_NONE;
        p = DSC_FRAME_RST;
        i = $urandom(26927);
        repeat (20) @(posedge CORE_CLK);
        NRST <= 1'b1;
        apb(1'b0, DSC_ADDR_STATUS, 32'h0, '{1'b0, 1'b1, st()});
        apb(1'b0, 8'h18, 32'h0, '{1'b1, 1'b1, 32'h0});
        apb(1'b1, DSC_ADDR_STATUS, 32'h5, '{1'b1, 1'b0, 32'h0});
        apb(1'b0, DSC_ADDR_STATUS, 32'h0, '{1'b0, 1'b1, st()});
        for (i = 0; i < 300; i++) begin
            c = p;
            c.bw = dsc_bw_t'((i % 9 == 0) ? $urandom_range(3) : $urandom_range(2, 1));
            c.total_brate = brt[$urandom_range(3)];
            c.core_brate = $urandom_range(2500, 2300);
            c.output_sample_rate = fst[$urandom_range(2)];
            c.coder_type = dsc_ct_t'($urandom_range(5));
            c.core = dsc_core_t'($urandom_range(2));
            {c.ppp_mode, c.legacy_interop_mode, c.pf_on, c.internal_rate} = 5'($urandom);
            frame(i % 7 == 0);
        end
        final_report();
    end
endmodule
